// *** rtl/core_registers_and_pc_sequencer.sv ***
`timescale 1ns/100ps
// What this block does
// - five visible registers, three flag pairs
// - sum register is eight bit working register
// - sum register mapped at data address ff
// - pointers mapped at data addresses 80, 81
// - indirect mode uses pointer contents as address
// - pointers reachable direct, short and bitwise
// - short slots mapped at data addresses 82, 83
// - short direct form names slot in fewer bytes
// - short slots reachable direct and bitwise
// - twelve bit fetch pointer, 4096 locations
// - larger program space via bank switch, not width
// - ordinary instruction increments fetch pointer by one
// - relative branch adds signed offset through alu
// - jump, call, vector, pop load fetch pointer
// - reset restarts execution at program start
// - unmaskable request caught on falling edge
// - per context flag pairs, restored on return
// - reset starts in unmaskable context
// - six level return stack, deepest lost
module core_registers_and_pc_sequencer
(
	input  wire logic                        clk,
	input  wire logic                        reset,
	input  wire logic                        unmaskable_irq_line_n,
	input  wire logic                        factory_mode_pin,
	input  wire core_pkg::pc_cmd_t           pc_cmd,
	input  wire logic [core_pkg::DATA_W-1:0] rom_data,
	input  wire core_pkg::ds_req_t           ds_req,
	input  wire logic                        acc_we,
	input  wire logic [core_pkg::DATA_W-1:0] acc_wdata,
	input  wire core_pkg::flag_upd_t         flag_upd,
	output logic      [core_pkg::PC_W-1:0]   rom_addr_r,
	output logic      [core_pkg::PC_W-1:0]   fetch_pointer_r,
	output logic                             busy_r,
	output logic      [core_pkg::DATA_W-1:0] ds_rdata_r,
	output logic                             ds_hit_r,
	output core_pkg::ds_fwd_t                ds_fwd_r,
	output logic      [core_pkg::DATA_W-1:0] sum_register_r,
	output logic      [core_pkg::DATA_W-1:0] pointer_one_r,
	output logic      [core_pkg::DATA_W-1:0] pointer_two_r,
	output logic      [core_pkg::DATA_W-1:0] short_slot_one_r,
	output logic      [core_pkg::DATA_W-1:0] short_slot_second_r,
	output core_pkg::ctx_t                   ctx_r,
	output logic      [core_pkg::NUM_CTX-1:0] carry_r,
	output logic      [core_pkg::NUM_CTX-1:0] zero_r,
	output logic                             nmi_pending_r,
	output logic                             special_mode_r,
	output logic                             stack_empty_r
);

	// ---------------------------------------------------------------
	// decode helpers
	// ---------------------------------------------------------------

	// map a data space address onto a core register
	function automatic core_pkg::core_idx_t core_index
	(
		input logic [core_pkg::DATA_W-1:0] addr
	);
		case (addr)
			core_pkg::ADDR_POINTER_ONE: core_index = core_pkg::IDX_POINTER_ONE;
			core_pkg::ADDR_POINTER_TWO: core_index = core_pkg::IDX_POINTER_TWO;
			core_pkg::ADDR_SLOT_ONE:    core_index = core_pkg::IDX_SLOT_ONE;
			core_pkg::ADDR_SLOT_SECOND: core_index = core_pkg::IDX_SLOT_SECOND;
			core_pkg::ADDR_SUM:         core_index = core_pkg::IDX_SUM;
			default:                    core_index = core_pkg::IDX_NONE;
		endcase
	endfunction

	// replace one bit of a byte for bit direct writes
	function automatic logic [core_pkg::DATA_W-1:0] put_bit
	(
		input logic [core_pkg::DATA_W-1:0] cur,
		input logic [core_pkg::BIT_W-1:0]  num,
		input logic                        val
	);
		logic [core_pkg::DATA_W-1:0] res;
		res      = cur;
		res[num] = val;
		put_bit  = res;
	endfunction

	// alu adder used for relative branches
	function automatic logic [core_pkg::PC_W-1:0] alu_add
	(
		input logic [core_pkg::PC_W-1:0]   base,
		input logic [core_pkg::DATA_W-1:0] off
	);
		logic [core_pkg::PC_W-1:0] ext;
		ext     = core_pkg::PC_W'($signed(off));
		alu_add = base + ext;
	endfunction

	// ---------------------------------------------------------------
	// internal signals
	// ---------------------------------------------------------------

	logic [core_pkg::DATA_W-1:0] core_r [core_pkg::NUM_CORE]; // registers
	core_pkg::seq_state_t        state_r;      // sequencer state
	logic [core_pkg::DATA_W-1:0] vec_lo_r;     // captured vector low byte
	logic [core_pkg::PC_W-1:0]   pc_nxt;       // next fetch pointer
	logic                        stk_push;     // return stack push
	logic                        stk_pop;      // return stack pop
	logic [core_pkg::PC_W-1:0]   stk_top;      // top of return stack
	logic                        stk_empty;    // nothing to return to
	core_pkg::ctx_t              nmi_prev_r;   // context before nmi
	logic                        nmi_meta_r;   // synchroniser stage one
	logic                        nmi_sync_r;   // synchroniser stage two
	logic                        nmi_old_r;    // previous synced level
	logic [core_pkg::DATA_W-1:0] ea;           // effective address
	core_pkg::core_idx_t         acc_idx;      // register hit by access
	logic                        run;          // commands accepted

	assign run = (state_r == core_pkg::ST_RUN);

	// register outputs straight from the register array
	assign pointer_one_r       = core_r[core_pkg::IDX_POINTER_ONE];
	assign pointer_two_r       = core_r[core_pkg::IDX_POINTER_TWO];
	assign short_slot_one_r    = core_r[core_pkg::IDX_SLOT_ONE];
	assign short_slot_second_r = core_r[core_pkg::IDX_SLOT_SECOND];
	assign sum_register_r      = core_r[core_pkg::IDX_SUM];

	// ---------------------------------------------------------------
	// data space address resolution
	// ---------------------------------------------------------------

	// indirect takes the pointer, short picks one of four core slots
	always_comb
	begin
		case (ds_req.mode)
			core_pkg::AM_INDIRECT:
				ea = ds_req.sel[0] ? core_r[core_pkg::IDX_POINTER_TWO]
				                   : core_r[core_pkg::IDX_POINTER_ONE];
			core_pkg::AM_SHORT:
				// two bit slot number replaces a full address byte
				ea = core_pkg::SHORT_BASE
				   | core_pkg::DATA_W'(ds_req.sel);
			default:
				ea = ds_req.addr;
		endcase
		acc_idx = ds_req.req ? core_index(ea) : core_pkg::IDX_NONE;
	end

	// ---------------------------------------------------------------
	// core registers
	// ---------------------------------------------------------------

	// data space write beats an alu result to the sum register
	genvar g;
	generate
		for (g = 0; g < core_pkg::NUM_CORE; g++)
		begin : g_core
			always_ff @(posedge clk)
			begin
				if (reset)
					core_r[g] <= core_pkg::REG_RESET;
				else if (ds_req.we && acc_idx == core_pkg::core_idx_t'(g))
					// same edge as an alu result would land
					core_r[g] <= ds_req.bit_en
					           ? put_bit(core_r[g], ds_req.bit_num,
					                     ds_req.bit_val)
					           : ds_req.wdata;
				else if (acc_we && g == core_pkg::IDX_SUM)
					core_r[g] <= acc_wdata;
			end
		end
	endgenerate

	// read data one edge after the request; misses read as zero so an
	// outer mux can or them in
	always_ff @(posedge clk)
	begin
		if (reset || acc_idx == core_pkg::IDX_NONE)
		begin
			ds_rdata_r <= core_pkg::DATA_ZERO;
			ds_hit_r   <= 1'b0;
		end
		else
		begin
			ds_rdata_r <= core_r[acc_idx];
			ds_hit_r   <= 1'b1;
		end
	end

	// misses are handed on, already resolved, to the rest of data space
	always_ff @(posedge clk)
	begin
		if (reset)
			ds_fwd_r <= '0;
		else
		begin
			ds_fwd_r.valid   <= ds_req.req && acc_idx == core_pkg::IDX_NONE;
			ds_fwd_r.we      <= ds_req.we;
			ds_fwd_r.addr    <= ea;
			ds_fwd_r.wdata   <= ds_req.wdata;
			ds_fwd_r.bit_en  <= ds_req.bit_en;
			ds_fwd_r.bit_num <= ds_req.bit_num;
			ds_fwd_r.bit_val <= ds_req.bit_val;
		end
	end

	// ---------------------------------------------------------------
	// fetch pointer sequencing
	// ---------------------------------------------------------------

	// the pointer wraps at twelve bits; banks are selected elsewhere
	always_comb
	begin
		pc_nxt   = fetch_pointer_r;
		stk_push = 1'b0;
		stk_pop  = 1'b0;
		case (state_r)
			core_pkg::ST_VEC_HI:
				pc_nxt = {rom_data[core_pkg::VEC_HI_W-1:0], vec_lo_r};
			core_pkg::ST_RUN:
			begin
				case (pc_cmd.op)
					core_pkg::PC_INCR:
						pc_nxt = fetch_pointer_r + core_pkg::PC_ONE;
					core_pkg::PC_JUMP:
						pc_nxt = pc_cmd.target;
					core_pkg::PC_CALL:
					begin
						pc_nxt   = pc_cmd.target;
						stk_push = 1'b1;
					end
					core_pkg::PC_BRANCH:
						pc_nxt = alu_add(fetch_pointer_r, pc_cmd.offset);
					core_pkg::PC_IRQ:
					begin
						pc_nxt   = core_pkg::VEC_IRQ_BASE
						         | {9'h000, pc_cmd.irq_sel, 1'b0};
						stk_push = 1'b1;
					end
					core_pkg::PC_NMI:
					begin
						pc_nxt   = core_pkg::VEC_NMI;
						stk_push = 1'b1;
					end
					core_pkg::PC_RET, core_pkg::PC_LEAVE_INTERRUPT:
					begin
						// empty stack just runs on to the next instruction
						if (stk_empty)
							pc_nxt = fetch_pointer_r + core_pkg::PC_ONE;
						else
						begin
							pc_nxt  = stk_top;
							stk_pop = 1'b1;
						end
					end
					default:
						pc_nxt = fetch_pointer_r;
				endcase
			end
			default:
				pc_nxt = fetch_pointer_r;
		endcase
	end

	// reset vector fetch, then commands are accepted
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			state_r  <= core_pkg::ST_VEC_LO;
			vec_lo_r <= core_pkg::DATA_ZERO;
			busy_r   <= 1'b1;
		end
		else
		begin
			case (state_r)
				core_pkg::ST_VEC_LO:
				begin
					vec_lo_r <= rom_data;
					state_r  <= core_pkg::ST_VEC_HI;
				end
				core_pkg::ST_VEC_HI:
				begin
					state_r <= core_pkg::ST_RUN;
					busy_r  <= 1'b0;
				end
				core_pkg::ST_RUN:
					busy_r <= 1'b0;
				default:
					state_r <= core_pkg::ST_VEC_LO;
			endcase
		end
	end

	// fetch pointer and the rom address it drives
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			fetch_pointer_r <= core_pkg::PC_RESET;
			rom_addr_r      <= core_pkg::VEC_RESET_LO;
		end
		else
		begin
			fetch_pointer_r <= pc_nxt;
			rom_addr_r      <= (state_r == core_pkg::ST_VEC_LO)
			                 ? core_pkg::VEC_RESET_HI : pc_nxt;
		end
	end

	// return addresses live outside data space
	return_stack u_stack
	(
		.clk       (clk),
		.reset     (reset),
		.push      (stk_push),
		.pop       (stk_pop),
		.push_data (fetch_pointer_r),
		.top       (stk_top),
		.empty     (stk_empty)
	);

	// registered copy of the stack state for observers
	always_ff @(posedge clk)
	begin
		if (reset)
			stack_empty_r <= 1'b1;
		else
			stack_empty_r <= stk_empty;
	end

	// ---------------------------------------------------------------
	// unmaskable request and mode pin
	// ---------------------------------------------------------------

	// two stage synchroniser; only the second stage is edge checked
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			nmi_meta_r <= 1'b1;
			nmi_sync_r <= 1'b1;
			nmi_old_r  <= 1'b1;
		end
		else
		begin
			nmi_meta_r <= unmaskable_irq_line_n;
			nmi_sync_r <= nmi_meta_r;
			nmi_old_r  <= nmi_sync_r;
		end
	end

	// a new edge wins over the acknowledge in the same cycle
	always_ff @(posedge clk)
	begin
		if (reset)
			nmi_pending_r <= 1'b0;
		else if (nmi_old_r && !nmi_sync_r)
			nmi_pending_r <= 1'b1;
		else if (run && pc_cmd.op == core_pkg::PC_NMI)
			nmi_pending_r <= 1'b0;
	end

	// only the level is reported; entering the test mode is elsewhere
	always_ff @(posedge clk)
	begin
		if (reset)
			special_mode_r <= 1'b0;
		else
			special_mode_r <= factory_mode_pin;
	end

	// ---------------------------------------------------------------
	// flag contexts
	// ---------------------------------------------------------------

	// context switches on entry and returns on leave_interrupt
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ctx_r      <= core_pkg::CTX_NMI;
			nmi_prev_r <= core_pkg::CTX_NORMAL;
		end
		else if (run)
		begin
			case (pc_cmd.op)
				core_pkg::PC_IRQ:
					ctx_r <= core_pkg::CTX_IRQ;
				core_pkg::PC_NMI:
				begin
					nmi_prev_r <= ctx_r;
					ctx_r      <= core_pkg::CTX_NMI;
				end
				core_pkg::PC_LEAVE_INTERRUPT:
				begin
					// nmi returns to what it interrupted
					if (ctx_r == core_pkg::CTX_NMI)
						ctx_r <= nmi_prev_r;
					else
						ctx_r <= core_pkg::CTX_NORMAL;
				end
				default:
					ctx_r <= ctx_r;
			endcase
		end
	end

	// each pair changes only while its own context is active
	generate
		for (g = 0; g < core_pkg::NUM_CTX; g++)
		begin : g_flag
			always_ff @(posedge clk)
			begin
				if (reset)
				begin
					carry_r[g] <= 1'b0;
					zero_r[g]  <= 1'b0;
				end
				else if (flag_upd.we && ctx_r == core_pkg::ctx_t'(g))
				begin
					carry_r[g] <= flag_upd.carry;
					zero_r[g]  <= flag_upd.zero;
				end
			end
		end
	endgenerate

endmodule

// *** common/core_pkg.sv ***
// ---------------------------------------------------------------
// core register and sequencer definitions
// ---------------------------------------------------------------
package core_pkg;

	localparam int DATA_W      = 8;  // data space width
	localparam int PC_W        = 12; // fetch pointer width
	localparam int VEC_HI_W    = PC_W - DATA_W; // vector high part
	localparam int STACK_DEPTH = 6;  // return stack levels
	localparam int NUM_CTX     = 3;  // flag contexts
	localparam int NUM_CORE    = 5;  // mapped core registers
	localparam int BIT_W       = 3;  // bit number width

	// data space locations of the core registers
	localparam logic [DATA_W-1:0] ADDR_POINTER_ONE  = 8'h80;
	localparam logic [DATA_W-1:0] ADDR_POINTER_TWO  = 8'h81;
	localparam logic [DATA_W-1:0] ADDR_SLOT_ONE     = 8'h82;
	localparam logic [DATA_W-1:0] ADDR_SLOT_SECOND  = 8'h83;
	localparam logic [DATA_W-1:0] ADDR_SUM          = 8'hff;
	localparam logic [DATA_W-1:0] SHORT_BASE        = 8'h80;

	// program space vectors
	localparam logic [PC_W-1:0] VEC_RESET_LO = 12'hffe;
	localparam logic [PC_W-1:0] VEC_RESET_HI = 12'hfff;
	localparam logic [PC_W-1:0] VEC_NMI      = 12'hffc;
	localparam logic [PC_W-1:0] VEC_IRQ_BASE = 12'hff0;
	localparam logic [PC_W-1:0] PC_RESET     = 12'h000;
	localparam logic [PC_W-1:0] PC_ONE       = 12'h001;

	// reset values
	localparam logic [DATA_W-1:0] REG_RESET  = 8'h00;
	localparam logic [DATA_W-1:0] DATA_ZERO  = 8'h00;

	// decoded core register index
	typedef enum logic [2:0] {
		IDX_POINTER_ONE,
		IDX_POINTER_TWO,
		IDX_SLOT_ONE,
		IDX_SLOT_SECOND,
		IDX_SUM,
		IDX_NONE
	} core_idx_t;

	// fetch pointer update requested by the instruction logic
	typedef enum logic [3:0] {
		PC_HOLD,
		PC_INCR,
		PC_JUMP,
		PC_CALL,
		PC_BRANCH,
		PC_IRQ,
		PC_NMI,
		PC_RET,
		PC_LEAVE_INTERRUPT
	} pc_op_t;

	// flag context
	typedef enum logic [1:0] {
		CTX_NORMAL,
		CTX_IRQ,
		CTX_NMI
	} ctx_t;

	// data space addressing mode
	typedef enum logic [1:0] {
		AM_DIRECT,
		AM_INDIRECT,
		AM_SHORT
	} addr_mode_t;

	// sequencer state
	typedef enum logic [1:0] {
		ST_VEC_LO,
		ST_VEC_HI,
		ST_RUN
	} seq_state_t;

	// fetch pointer command
	typedef struct packed {
		pc_op_t            op;
		logic [PC_W-1:0]   target;
		logic [DATA_W-1:0] offset;
		logic [1:0]        irq_sel;
	} pc_cmd_t;

	// data space access from the instruction logic
	typedef struct packed {
		logic              req;
		logic              we;
		addr_mode_t        mode;
		logic [1:0]        sel;
		logic [DATA_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              bit_en;
		logic [BIT_W-1:0]  bit_num;
		logic              bit_val;
	} ds_req_t;

	// resolved access passed on to the rest of data space
	typedef struct packed {
		logic              valid;
		logic              we;
		logic [DATA_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              bit_en;
		logic [BIT_W-1:0]  bit_num;
		logic              bit_val;
	} ds_fwd_t;

	// flag update from the alu
	typedef struct packed {
		logic we;
		logic carry;
		logic zero;
	} flag_upd_t;

endpackage

// *** rtl/return_stack.sv ***
`timescale 1ns/100ps
// ---------------------------------------------------------------
// return address stack
// ---------------------------------------------------------------
module return_stack
(
	input  wire logic                     clk,
	input  wire logic                     reset,
	input  wire logic                     push,
	input  wire logic                     pop,
	input  wire logic [core_pkg::PC_W-1:0] push_data,
	output logic      [core_pkg::PC_W-1:0] top,
	output logic                          empty
);

	localparam int LAST = core_pkg::STACK_DEPTH - 1;
	localparam logic [2:0] DEPTH_MAX = 3'(core_pkg::STACK_DEPTH);
	localparam logic [2:0] DEPTH_ONE = 3'h1;

	logic [core_pkg::PC_W-1:0] lvl_r [core_pkg::STACK_DEPTH]; // levels
	logic [2:0]                depth_r;                       // fill

	assign top   = lvl_r[0];
	assign empty = (depth_r == 3'h0);

	// each level shifts down on push and up on pop
	genvar i;
	generate
		for (i = 0; i < core_pkg::STACK_DEPTH; i++)
		begin : g_lvl
			always_ff @(posedge clk)
			begin
				if (reset)
					lvl_r[i] <= core_pkg::PC_RESET;
				else if (push)
					// deepest value falls off the end
					lvl_r[i] <= (i == 0) ? push_data : lvl_r[(i == 0) ? 0 : i - 1];
				else if (pop)
					lvl_r[i] <= (i == LAST) ? lvl_r[i] : lvl_r[(i == LAST) ? i : i + 1];
			end
		end
	endgenerate

	// fill count saturates both ways
	always_ff @(posedge clk)
	begin
		if (reset)
			depth_r <= 3'h0;
		else if (push && depth_r != DEPTH_MAX)
			depth_r <= depth_r + DEPTH_ONE;
		else if (pop && !push && depth_r != 3'h0)
			depth_r <= depth_r - DEPTH_ONE;
	end

endmodule

// *** tb/prog_rom.sv ***
`timescale 1ns/100ps
// --------
// program rom stand-in, answers in the cycle of the address
// --------
module prog_rom
(
	input  wire logic [core_pkg::PC_W-1:0]   addr, // fetch address
	output logic      [core_pkg::DATA_W-1:0] data  // byte at that address
);
	// vector bytes plus a filler that changes with every address
	always_comb
	begin
		if (addr == core_pkg::VEC_RESET_LO)
			data = 8'h34; // low byte of the start address
		else if (addr == core_pkg::VEC_RESET_HI)
			data = 8'ha2; // upper nibble set to catch a leak
		else
			data = addr[7:0] ^ 8'h5a; // repeats the last vector byte only where the low address byte is f8
	end
endmodule

// *** tb/core_regs_monitor.sv ***
`timescale 1ns/100ps
// --------
// port checks for the core register block
// --------
module core_regs_monitor
(
	input wire logic                        clk,
	input wire logic                        reset,
	input wire logic                        unmaskable_irq_line_n,
	input wire core_pkg::pc_cmd_t           pc_cmd,
	input wire logic [core_pkg::DATA_W-1:0] rom_data,
	input wire core_pkg::ds_req_t           ds_req,
	input wire logic [core_pkg::PC_W-1:0]   fetch_pointer_r,
	input wire logic                        busy_r,
	input wire logic [core_pkg::DATA_W-1:0] ds_rdata_r,
	input wire logic                        ds_hit_r,
	input wire logic [core_pkg::DATA_W-1:0] sum_register_r,
	input wire logic [core_pkg::DATA_W-1:0] pointer_one_r,
	input wire core_pkg::ctx_t              ctx_r,
	input wire logic                        nmi_pending_r
);
	core_pkg::pc_op_t          op;      // command as taken, hold while busy
	logic [core_pkg::PC_W-1:0] off_ext; // sign extended branch offset
	logic                      ds_wr;   // whole byte data write
	assign op = busy_r ? core_pkg::PC_HOLD : pc_cmd.op;
	assign off_ext = {{4{pc_cmd.offset[7]}}, pc_cmd.offset};
	assign ds_wr = ds_req.req && ds_req.we && !ds_req.bit_en;

	default clocking mon_cb @(posedge clk);
	endclocking
	default disable iff (reset);

	a_reset_state: assert property (
		$fell(reset) |-> busy_r && ctx_r == core_pkg::CTX_NMI
		&& fetch_pointer_r == core_pkg::PC_RESET)
		else $error("state at reset release wrong");
	// vector is two rom bytes, low one first
	a_vector_load: assert property (
		$fell(reset) ##1 1'b1 |=> !busy_r
		&& fetch_pointer_r[7:0] == $past(rom_data, 2)
		&& {4'h0, fetch_pointer_r[11:8]} == ($past(rom_data) & 8'h0f))
		else $error("reset vector not loaded");
	a_incr_one: assert property (
		op == core_pkg::PC_INCR
		|=> fetch_pointer_r == $past(fetch_pointer_r) + 12'h001)
		else $error("increment wrong");
	a_branch_add: assert property (
		op == core_pkg::PC_BRANCH
		|=> fetch_pointer_r == $past(fetch_pointer_r) + $past(off_ext))
		else $error("branch sum wrong");
	a_call_return: assert property (
		op == core_pkg::PC_CALL ##1 op == core_pkg::PC_HOLD
		##1 op == core_pkg::PC_RET |=> fetch_pointer_r == $past(fetch_pointer_r, 3))
		else $error("return address wrong");
	a_sum_read: assert property (
		ds_req.req && !ds_req.we && ds_req.mode == core_pkg::AM_DIRECT
		&& ds_req.addr == core_pkg::ADDR_SUM
		|=> ds_hit_r && ds_rdata_r == $past(sum_register_r))
		else $error("sum register read wrong");
	a_pointer_write: assert property (
		ds_wr && ds_req.mode == core_pkg::AM_DIRECT
		&& ds_req.addr == core_pkg::ADDR_POINTER_ONE
		|=> pointer_one_r == $past(ds_req.wdata))
		else $error("pointer write lost");
	// sync chain costs three edges
	a_nmi_catch: assert property (
		$fell(unmaskable_irq_line_n) |-> ##[1:4] nmi_pending_r)
		else $error("falling request missed");
endmodule

bind core_registers_and_pc_sequencer core_regs_monitor mon_u (
	.clk(clk), .reset(reset), .unmaskable_irq_line_n(unmaskable_irq_line_n),
	.pc_cmd(pc_cmd), .rom_data(rom_data), .ds_req(ds_req),
	.fetch_pointer_r(fetch_pointer_r), .busy_r(busy_r),
	.ds_rdata_r(ds_rdata_r), .ds_hit_r(ds_hit_r),
	.sum_register_r(sum_register_r), .pointer_one_r(pointer_one_r),
	.ctx_r(ctx_r), .nmi_pending_r(nmi_pending_r)
);

// *** tb/core_registers_and_pc_sequencer_tb.sv ***
`timescale 1ns/100ps
module core_registers_and_pc_sequencer_tb;
	// --------
	// data space rows and signals
	// --------
	typedef struct packed {
		logic                        we;   // write row, else read row
		core_pkg::addr_mode_t        mode; // addressing form
		logic [1:0]                  sel;  // pointer or slot select
		logic [core_pkg::DATA_W-1:0] addr; // direct address
		logic [core_pkg::DATA_W-1:0] data; // write data or read result
		logic                        hit;  // core location expected
	} row_t;
	localparam core_pkg::addr_mode_t DIR = core_pkg::AM_DIRECT;
	localparam core_pkg::addr_mode_t IND = core_pkg::AM_INDIRECT;
	localparam core_pkg::addr_mode_t SHT = core_pkg::AM_SHORT;
	// pointer_one first aims off-core for a miss
	localparam row_t ROWS [14] = '{
		'{1'b1, DIR, 2'h0, 8'h80, 8'h90, 1'b0},
		'{1'b0, IND, 2'h0, 8'h00, 8'h00, 1'b0},
		'{1'b1, DIR, 2'h0, 8'h80, 8'ha1, 1'b0},
		'{1'b1, DIR, 2'h0, 8'h81, 8'h82, 1'b0},
		'{1'b1, SHT, 2'h2, 8'h00, 8'hc3, 1'b0},
		'{1'b1, SHT, 2'h3, 8'h00, 8'hd4, 1'b0},
		'{1'b1, DIR, 2'h0, 8'hff, 8'he5, 1'b0},
		'{1'b0, DIR, 2'h0, 8'h80, 8'ha1, 1'b1},
		'{1'b0, SHT, 2'h1, 8'h00, 8'h82, 1'b1},
		'{1'b0, DIR, 2'h0, 8'h82, 8'hc3, 1'b1},
		'{1'b0, DIR, 2'h0, 8'h83, 8'hd4, 1'b1},
		'{1'b0, IND, 2'h1, 8'h00, 8'hc3, 1'b1},
		'{1'b0, DIR, 2'h0, 8'hff, 8'he5, 1'b1},
		'{1'b0, DIR, 2'h0, 8'h90, 8'h00, 1'b0}
	};
	logic                         clk;
	logic                         reset;
	logic                         unmaskable_irq_line_n;
	logic                         factory_mode_pin;
	core_pkg::pc_cmd_t            pc_cmd;
	logic [core_pkg::DATA_W-1:0]  rom_data;
	core_pkg::ds_req_t            ds_req;
	logic                         acc_we;
	logic [core_pkg::DATA_W-1:0]  acc_wdata;
	core_pkg::flag_upd_t          flag_upd;
	logic [core_pkg::PC_W-1:0]    rom_addr_r;
	logic [core_pkg::PC_W-1:0]    fetch_pointer_r;
	logic                         busy_r;
	logic [core_pkg::DATA_W-1:0]  ds_rdata_r;
	logic                         ds_hit_r;
	logic [core_pkg::DATA_W-1:0]  sum_register_r;
	core_pkg::ctx_t               ctx_r;
	logic [core_pkg::NUM_CTX-1:0] carry_r;
	logic [core_pkg::NUM_CTX-1:0] zero_r;
	logic                         nmi_pending_r;
	logic                         special_mode_r;
	logic                         stack_empty_r;
	int                           error_cnt; // mismatches seen
	int                           checked;   // comparisons made
	int                           cycles;    // clock edges since start

	core_registers_and_pc_sequencer dut_u (
		.clk(clk), .reset(reset), .unmaskable_irq_line_n(unmaskable_irq_line_n),
		.factory_mode_pin(factory_mode_pin), .pc_cmd(pc_cmd),
		.rom_data(rom_data), .ds_req(ds_req), .acc_we(acc_we),
		.acc_wdata(acc_wdata), .flag_upd(flag_upd), .rom_addr_r(rom_addr_r),
		.fetch_pointer_r(fetch_pointer_r), .busy_r(busy_r),
		.ds_rdata_r(ds_rdata_r), .ds_hit_r(ds_hit_r), .ds_fwd_r(),
		.sum_register_r(sum_register_r), .pointer_one_r(), .pointer_two_r(),
		.short_slot_one_r(), .short_slot_second_r(), .ctx_r(ctx_r),
		.carry_r(carry_r), .zero_r(zero_r), .nmi_pending_r(nmi_pending_r),
		.special_mode_r(special_mode_r), .stack_empty_r(stack_empty_r)
	);
	prog_rom rom_u (.addr(rom_addr_r), .data(rom_data));

	// --------
	// clock, hang guard and helpers
	// --------
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// trips only on a hang
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			error_cnt++;
			complete_run();
		end
	end
	task automatic complete_run();
		if (error_cnt == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk_pc(input logic [11:0] got, input logic [11:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t pointer %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t value %h expected %h", $time, got, exp);
		end
	endtask
	// one data access, results land one edge after the request
	task automatic ds_acc(input row_t r, input logic bit_en);
		@(posedge clk);
		ds_req <= '{1'b1, r.we, r.mode, r.sel, r.addr, r.data, bit_en,
			3'h0, 1'b1};
		@(posedge clk);
		ds_req.req <= 1'b0;
		#1;
	endtask
	// one command, then hold so it acts exactly once
	task automatic do_pc(input core_pkg::pc_op_t op, input logic [11:0] exp,
		input logic [11:0] tgt = 12'h000, input logic [7:0] off = 8'h00,
		input logic [1:0] sel = 2'h0);
		@(posedge clk);
		pc_cmd <= '{op, tgt, off, sel};
		@(posedge clk);
		pc_cmd.op <= core_pkg::PC_HOLD;
		#1;
		chk_pc(fetch_pointer_r, exp);
	endtask
	task automatic do_flag(input logic c, input logic z);
		@(posedge clk);
		flag_upd <= '{1'b1, c, z};
		@(posedge clk);
		flag_upd.we <= 1'b0;
		#1;
	endtask
	// wait out the vector fetch, start is 234
	task automatic wait_ready();
		for (int n = 0; n < 8 && busy_r !== 1'b0; n++)
			@(posedge clk);
		#1;
		chk_pc(fetch_pointer_r, 12'h234);
		chk_byte({6'h0, ctx_r}, 8'h02);
	endtask

	// --------
	// main sequence
	// --------
	initial
	begin
		reset = 1'b1;
		unmaskable_irq_line_n = 1'b1;
		factory_mode_pin = 1'b0;
		pc_cmd = '0;
		ds_req = '0;
		acc_we = 1'b0;
		acc_wdata = 8'h00;
		flag_upd = '0;
		error_cnt = 0;
		checked = 0;
		cycles = 0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		wait_ready();
		chk_byte({7'h0, special_mode_r}, 8'h00);
		foreach (ROWS[i])
		begin
			ds_acc(ROWS[i], 1'b0);
			if (!ROWS[i].we)
			begin
				chk_byte(ds_rdata_r, ROWS[i].data);
				chk_byte({7'h0, ds_hit_r}, {7'h0, ROWS[i].hit});
			end
		end
		// single bit set on a short slot keeps the other bits
		ds_acc('{1'b1, SHT, 2'h3, 8'h00, 8'h00, 1'b0}, 1'b1);
		ds_acc('{1'b0, SHT, 2'h3, 8'h00, 8'h00, 1'b0}, 1'b0);
		chk_byte(ds_rdata_r, 8'hd5);
		@(posedge clk);
		acc_we <= 1'b1;
		acc_wdata <= 8'h77;
		@(posedge clk);
		acc_we <= 1'b0;
		#1;
		chk_byte(sum_register_r, 8'h77);
		do_pc(core_pkg::PC_INCR, 12'h235);
		do_pc(core_pkg::PC_JUMP, 12'hffa, 12'hffa);
		do_pc(core_pkg::PC_BRANCH, 12'h00a, 12'h000, 8'h10);
		do_pc(core_pkg::PC_BRANCH, 12'hffa, 12'h000, 8'hf0);
		// seven calls, so the oldest return address falls off
		for (int i = 0; i < 7; i++)
			do_pc(core_pkg::PC_CALL, 12'(12'h100 + i),
				12'(12'h100 + i));
		for (int i = 0; i < 6; i++)
			do_pc(core_pkg::PC_RET, 12'(12'h105 - i));
		do_pc(core_pkg::PC_RET, 12'h101);
		chk_byte({7'h0, stack_empty_r}, 8'h01);
		do_pc(core_pkg::PC_IRQ, 12'hff2, 12'h000, 8'h00, 2'h1);
		do_flag(1'b1, 1'b0);
		do_pc(core_pkg::PC_LEAVE_INTERRUPT, 12'h101);
		chk_byte({6'h0, ctx_r}, 8'h00);
		do_flag(1'b0, 1'b1);
		chk_byte({2'h0, carry_r, zero_r}, 8'h11);
		@(posedge clk);
		unmaskable_irq_line_n <= 1'b0;
		for (int n = 0; n < 8 && nmi_pending_r !== 1'b1; n++)
			@(posedge clk);
		#1;
		chk_byte({7'h0, nmi_pending_r}, 8'h01);
		do_pc(core_pkg::PC_NMI, 12'hffc);
		chk_byte({5'h0, ctx_r, nmi_pending_r}, 8'h04);
		do_pc(core_pkg::PC_LEAVE_INTERRUPT, 12'h101);
		chk_byte({6'h0, ctx_r}, 8'h00);
		// mid-run reset restarts from the vector
		@(posedge clk);
		reset <= 1'b1;
		unmaskable_irq_line_n <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		wait_ready();
		complete_run();
	end
endmodule
